// [pkg/tpo_pkg.sv]
// Package for the timer prescaler and option control block.
// Assumes an 8-bit register port with one-cycle strobes and read data one cycle later.
package tpo_pkg;
	localparam logic [7:0] OPT_ADDR = 8'h81;
	localparam logic [7:0] IRQCTL_ADDR = 8'h8B;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'hF0;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'hF1;
	localparam logic [7:0] OPT_RESET = 8'hFF;
	localparam logic [7:0] IRQCTL_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam int OPT_PULLUP_BIT = 7;
	localparam int OPT_EDGE_BIT = 6;
	localparam int OPT_SRC_BIT = 5;
	localparam int OPT_SRC_EDGE_BIT = 4;
	localparam int OPT_ASSIGN_BIT = 3;
	localparam int IRQ_GIE_BIT = 7;
	localparam int IRQ_TMR_EN_BIT = 5;
	localparam int IRQ_EXT_EN_BIT = 4;
	localparam int IRQ_PORT_EN_BIT = 3;
	localparam int IRQ_TMR_FLAG_BIT = 2;
	localparam int IRQ_EXT_FLAG_BIT = 1;
	localparam int IRQ_PORT_FLAG_BIT = 0;
	localparam int STAT_TICK_BIT = 0;
	localparam int STAT_WDT_BIT = 1;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tpo_bus_req_t;
endpackage : tpo_pkg

// [tb/tb_top.sv]
// Self-checking bench for the option register, shared prescaler and flag logic.
// Assumes reads answer one cycle after the strobe and pins pass a 2-flop sync.
`timescale 1ns/1ps
module tb_top;
	import tpo_pkg::*;
	logic clk = 0, rstn = 0, cyc = 0, tpin = 0, epin = 0, tovf = 0, wtk = 0, rd_p = 0;
	tpo_bus_req_t req = '0;
	logic [7:0] rdata, pue, v, lat = 8'h00, pb = 8'h00;
	logic ttk, wto, cirq, irq;
	int n_mismatch = 0, checks = 0, ticks = 0, wticks = 0;
	logic [15:0] exp_q[$];
	always #4 clk = ~clk;
	tpo_option_ctrl dut (.clk(clk), .rstn(rstn), .bus_req(req), .rdata(rdata),
		.cycle_clock_out(cyc), .timer_ext_clk_pin(tpin), .ext_irq_pin(epin),
		.port_b_a(pb), .port_b_latch(lat), .timer_overflow(tovf), .wdt_tick(wtk),
		.pullup_en(pue), .timer_tick(ttk), .wdt_timeout(wto), .cpu_irq(cirq), .irq(irq));
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	// Read data is only valid in the cycle after the strobe
	always @(posedge clk)
	begin
		if (rd_p)
			check({8'h00, rdata}, exp_q.pop_front());
		rd_p <= req.rd;
		if (ttk === 1'b1)
			ticks++;
		if (wto === 1'b1)
			wticks++;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		exp_q.push_back({8'h00, e});
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : rd
	// Bounded wait on either interrupt level; running out ends the run
	task automatic wait_lvl(input logic use_irq, input logic want);
		int n = 0;
		while ((use_irq ? irq : cirq) !== want && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		check({15'h0000, use_irq ? irq : cirq}, {15'h0000, want});
		if ((use_irq ? irq : cirq) !== want)
			wrap_up();
	endtask : wait_lvl
	// Prescaler is cleared by flipping the assignment first, so counts start aligned
	task automatic run(input logic [7:0] o, input logic pin, input int tg, input int want);
		wr(OPT_ADDR, o ^ 8'h08);
		wr(OPT_ADDR, o);
		ticks = 0;
		repeat (tg)
		begin
			if (pin)
				tpin <= ~tpin;
			else
				cyc <= ~cyc;
			@(posedge clk);
		end
		repeat (8) @(posedge clk);
		check(16'(ticks), 16'(want));
	endtask : run
	initial
	begin
		void'($urandom(32'h059B70C2));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(OPT_ADDR, 8'hFF);
		rd(IRQCTL_ADDR, IRQCTL_RESET);
		rd(IRQ_MASK_ADDR, IRQ_MASK_RESET);
		rd(8'h00, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 8; i++)
		begin
			v = {i[0], 7'($urandom())};
			lat <= 8'($urandom());
			wr(OPT_ADDR, v);
			rd(OPT_ADDR, v);
			check({8'h00, pue}, {8'h00, v[7] ? 8'h00 : lat});
		end
		$display("option and pull-up done");
		for (int e = 0; e < 2; e++)
		begin
			wr(OPT_ADDR, e[0] ? 8'h40 : 8'h00);
			for (int k = 0; k < 2; k++)
			begin
				wr(IRQCTL_ADDR, 8'h00);
				epin <= ~epin;
				repeat (6) @(posedge clk);
				rd(IRQCTL_ADDR, (epin == e[0]) ? 8'h02 : 8'h00);
			end
		end
		wr(IRQCTL_ADDR, 8'h00);
		pb <= 8'h10;
		repeat (6) @(posedge clk);
		rd(IRQCTL_ADDR, 8'h01);
		wr(IRQCTL_ADDR, 8'h00);
		tovf <= 1'b1;
		@(posedge clk);
		tovf <= 1'b0;
		repeat (3) @(posedge clk);
		rd(IRQCTL_ADDR, 8'h04);
		wait_lvl(1'b0, 1'b0);
		wr(IRQCTL_ADDR, 8'hA4);
		wait_lvl(1'b0, 1'b1);
		wr(IRQCTL_ADDR, 8'hA0);
		wait_lvl(1'b0, 1'b0);
		$display("flags done");
		for (int c = 0; c < 8; c++)
			run(8'(c), 1'b0, 1024, 512 >> (c + 1));
		run(8'h08, 1'b0, 1024, 512);
		run(8'h20, 1'b1, 1023, 256);
		run(8'h30, 1'b1, 1023, 256);
		$display("prescaler done");
		wait_lvl(1'b1, 1'b0);
		wr(IRQ_MASK_ADDR, 8'h01);
		wait_lvl(1'b1, 1'b1);
		wr(IRQ_STAT_ADDR, 8'h01);
		wait_lvl(1'b1, 1'b0);
		rd(IRQ_STAT_ADDR, 8'h00);
		$display("status interrupt done");
		for (int c = 0; c < 2; c++)
		begin
			wr(OPT_ADDR, 8'h00);
			wr(OPT_ADDR, 8'h08 | 8'(c));
			wticks = 0;
			repeat (64)
			begin
				wtk <= 1'b1;
				@(posedge clk);
				wtk <= 1'b0;
				@(posedge clk);
			end
			repeat (4) @(posedge clk);
			check(16'(wticks), 16'(64 >> c));
		end
		rd(IRQ_STAT_ADDR, 8'h02);
		$display("watchdog done");
		wrap_up();
	end
endmodule : tb_top

// [verilog/tpo_option_ctrl.sv]
// Option register, shared prescaler, timer source select and interrupt control flags.
// Assumes pins are asynchronous and the register port follows a one-cycle strobe protocol.
//
// Overview of operation
// [RULE1] Option register read/write, resets to all ones
// [RULE2] One prescaler, timer or watchdog, never both
// [RULE3] Rate field doubles ratio per code
// [RULE4] Timer one-to-one only via watchdog assignment
// [RULE5] Pull-up disable bit forces pull-ups off
// [RULE6] Edge bit picks external pin edge
// [RULE7] Source bit and source edge select clock
// [RULE8] Assignment bit gives prescaler to watchdog
// [RULE9] Control register holds enables and flags
// [RULE10] Flags set regardless of enable bits
// [RULE11] Software clears flag before enabling interrupt
`timescale 1ns/1ps
module tpo_option_ctrl
	import tpo_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire tpo_bus_req_t bus_req,
	output logic [7:0] rdata,
	input wire logic cycle_clock_out,
	input wire logic timer_ext_clk_pin,
	input wire logic ext_irq_pin,
	input wire logic [7:0] port_b_a,
	input wire logic [7:0] port_b_latch,
	input wire logic timer_overflow,
	input wire logic wdt_tick,
	output logic [7:0] pullup_en,
	output logic timer_tick,
	output logic wdt_timeout,
	output logic cpu_irq,
	output logic irq
);
	typedef struct packed
	{
		logic [7:0] opt;
		logic [7:0] ctl;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [7:0] rdata;
		logic [1:0] clk_sync;
		logic [1:0] int_sync;
		logic clk_prev;
		logic int_prev;
		logic [3:0] pb_sync1;
		logic [3:0] pb_sync2;
		logic [3:0] pb_prev;
		logic cyc_prev;
		logic [8:0] ps_seen;
	} tpo_state_t;
	tpo_state_t s_q, s_d;
	logic src_edge, ext_edge, cyc_edge, ps_in, ps_out, ps_clear, to_wdt;
	logic pb_change;
	logic [2:0] ps_shift;
	logic timer_raw;
	logic wdt_bypass;
	logic tmr_req;
	logic ext_req;
	logic port_req;

	function automatic logic edge_hit(input logic now, input logic prev, input logic rise);
		edge_hit = rise ? (now && !prev) : (!now && prev);
	endfunction : edge_hit

	// Source ticks per divider output: the watchdog table is one octave below the timer's
	function automatic logic [8:0] rate_ticks(input logic [2:0] code, input logic wdt);
		rate_ticks = wdt ? (9'h001 << code) : (9'h002 << code);
	endfunction : rate_ticks

	assign to_wdt = s_q.opt[OPT_ASSIGN_BIT]; // RULE8
	// RULE7
	assign src_edge = edge_hit(s_q.clk_sync[1], s_q.clk_prev, !s_q.opt[OPT_SRC_EDGE_BIT]);
	assign cyc_edge = cycle_clock_out && !s_q.cyc_prev;
	// RULE6
	assign ext_edge = edge_hit(s_q.int_sync[1], s_q.int_prev, s_q.opt[OPT_EDGE_BIT]);
	assign pb_change = s_q.pb_sync2 != s_q.pb_prev;
	// Reassigning the prescaler clears it so stale counts never leak across owners
	assign ps_clear = bus_req.wr && bus_req.addr == OPT_ADDR
		&& bus_req.wdata[OPT_ASSIGN_BIT] != s_q.opt[OPT_ASSIGN_BIT];

	// The divider only knows 1:2 and up, so the watchdog runs it one step
	// shorter and code zero bypasses it; the timer never gets that bypass.
	always_comb
	begin
		timer_raw = s_q.opt[OPT_SRC_BIT] ? src_edge : cyc_edge; // RULE7
		wdt_bypass = to_wdt && s_q.opt[2:0] == 3'h0; // RULE3
		if (to_wdt)
		begin
			ps_in = wdt_tick; // RULE2
			ps_shift = s_q.opt[2:0] - 3'h1; // RULE3
		end
		else
		begin
			ps_in = timer_raw; // RULE2
			ps_shift = s_q.opt[2:0]; // RULE3
		end
	end

	tpo_prescaler #(.WIDTH(8)) u_ps
	(
		.clk(clk),
		.rstn(rstn),
		.clear(ps_clear),
		.tick_in(ps_in),
		.shift(ps_shift),
		.tick_out(ps_out)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.clk_sync = {s_q.clk_sync[0], timer_ext_clk_pin};
		s_d.int_sync = {s_q.int_sync[0], ext_irq_pin};
		s_d.clk_prev = s_q.clk_sync[1];
		s_d.int_prev = s_q.int_sync[1];
		s_d.pb_sync1 = port_b_a[7:4];
		s_d.pb_sync2 = s_q.pb_sync1;
		s_d.pb_prev = s_q.pb_sync2;
		s_d.cyc_prev = cycle_clock_out;
		s_d.rdata = 8'h00;
		if (bus_req.wr)
		begin
			if (bus_req.addr == OPT_ADDR)
			begin
				s_d.opt = bus_req.wdata; // RULE1
			end
			else if (bus_req.addr == IRQCTL_ADDR)
			begin
				s_d.ctl = bus_req.wdata; // RULE9
			end
			else if (bus_req.addr == IRQ_STAT_ADDR)
			begin
				s_d.stat = s_q.stat & ~bus_req.wdata[1:0];
			end
			else if (bus_req.addr == IRQ_MASK_ADDR)
			begin
				s_d.mask = bus_req.wdata[1:0];
			end
		end
		if (bus_req.rd)
		begin
			if (bus_req.addr == OPT_ADDR)
			begin
				s_d.rdata = s_q.opt; // RULE1
			end
			else if (bus_req.addr == IRQCTL_ADDR)
			begin
				s_d.rdata = s_q.ctl;
			end
			else if (bus_req.addr == IRQ_STAT_ADDR)
			begin
				s_d.rdata = {6'h00, s_q.stat};
			end
			else if (bus_req.addr == IRQ_MASK_ADDR)
			begin
				s_d.rdata = {6'h00, s_q.mask};
			end
		end
		// Hardware set wins over a software clear in the same cycle
		if (timer_overflow)
		begin
			s_d.ctl[IRQ_TMR_FLAG_BIT] = 1'b1; // RULE10
		end
		if (ext_edge)
		begin
			s_d.ctl[IRQ_EXT_FLAG_BIT] = 1'b1; // RULE10
		end
		if (pb_change)
		begin
			s_d.ctl[IRQ_PORT_FLAG_BIT] = 1'b1; // RULE10
		end
		if (ps_out && !to_wdt)
		begin
			s_d.stat[STAT_TICK_BIT] = 1'b1;
		end
		if (to_wdt && wdt_timeout)
		begin
			s_d.stat[STAT_WDT_BIT] = 1'b1;
		end
		// Source ticks since the divider last fired; only the rate check reads it
		if (ps_clear)
		begin
			s_d.ps_seen = '0;
		end
		else if (ps_out)
		begin
			s_d.ps_seen = {8'h00, ps_in};
		end
		else if (ps_in)
		begin
			s_d.ps_seen = s_q.ps_seen + 9'h001;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.opt <= OPT_RESET; // RULE1
			s_q.ctl <= IRQCTL_RESET;
			s_q.mask <= IRQ_MASK_RESET[1:0];
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	// RULE5
	assign pullup_en = s_q.opt[OPT_PULLUP_BIT] ? 8'h00 : port_b_latch;
	// RULE3 RULE4: timer sees 1:1 only while the watchdog owns the prescaler, else at least 1:2; watchdog may see 1:1
	assign timer_tick = to_wdt ? timer_raw : ps_out;
	// RULE2 RULE3: watchdog code zero skips the divider altogether
	assign wdt_timeout = to_wdt ? (wdt_bypass ? wdt_tick : ps_out) : wdt_tick;
	// RULE11: the enable gates only the interrupt, never the flag
	always_comb
	begin
		tmr_req = s_q.ctl[IRQ_TMR_EN_BIT] && s_q.ctl[IRQ_TMR_FLAG_BIT];
		ext_req = s_q.ctl[IRQ_EXT_EN_BIT] && s_q.ctl[IRQ_EXT_FLAG_BIT];
		port_req = s_q.ctl[IRQ_PORT_EN_BIT] && s_q.ctl[IRQ_PORT_FLAG_BIT];
	end
	// A flag left over from before the enable still raises the request at once
	assign cpu_irq = s_q.ctl[IRQ_GIE_BIT] && (tmr_req || ext_req || port_req);
	assign irq = |(s_q.stat & s_q.mask);

	chk_opt_reset_ones: assert property (@(posedge clk) $rose(rstn) |-> s_q.opt == 8'hFF) // RULE1
		else $error("option register not all ones after reset");
	chk_opt_write_store: assert property (@(posedge clk) disable iff (!rstn)
		bus_req.wr && bus_req.addr == 8'h81 |=> s_q.opt == $past(bus_req.wdata)) // RULE1
		else $error("option write lost");
	chk_opt_read_back: assert property (@(posedge clk) disable iff (!rstn)
		bus_req.rd && bus_req.addr == 8'h81 |=> rdata == $past(s_q.opt)) // RULE1
		else $error("option read wrong");
	chk_ps_one_owner: assert property (@(posedge clk) disable iff (!rstn)
		to_wdt |-> timer_tick == (s_q.opt[5] ? src_edge : cyc_edge)) // RULE2
		else $error("prescaler serves both");
	chk_timer_min_two: assert property (@(posedge clk) disable iff (!rstn)
		!to_wdt && s_q.opt[2:0] == 3'h0 && ps_in && $past(ps_out) |-> !ps_out ##1 !ps_out) // RULE4
		else $error("timer divided below two");
	chk_pullup_off: assert property (@(posedge clk) disable iff (!rstn)
		s_q.opt[7] |-> pullup_en == 8'h00) // RULE5
		else $error("pull-ups not off");
	chk_ext_edge_flag: assert property (@(posedge clk) disable iff (!rstn)
		ext_edge |=> s_q.ctl[1]) // RULE6
		else $error("external edge did not set flag");
	chk_flag_no_enable: assert property (@(posedge clk) disable iff (!rstn)
		timer_overflow && !s_q.ctl[5] |=> s_q.ctl[2]) // RULE10
		else $error("flag not set while disabled");
	chk_src_internal: assert property (@(posedge clk) disable iff (!rstn)
		!to_wdt && !s_q.opt[5] |-> ps_in == cyc_edge) // RULE7
		else $error("wrong timer source");

	// Prescaler ownership and rate
	chk_rate_ratio: assert property (@(posedge clk) disable iff (!rstn)
		ps_out && !wdt_bypass |-> s_q.ps_seen == rate_ticks(s_q.opt[2:0], to_wdt)) // RULE3
		else $error("prescaler ratio wrong");
	chk_wdt_one_one: assert property (@(posedge clk) disable iff (!rstn)
		wdt_bypass |-> wdt_timeout == wdt_tick) // RULE3
		else $error("watchdog code zero not one to one");
	chk_wdt_owner_in: assert property (@(posedge clk) disable iff (!rstn)
		to_wdt |-> ps_in == wdt_tick) // RULE8
		else $error("prescaler not fed by watchdog");
	chk_timer_owner_in: assert property (@(posedge clk) disable iff (!rstn)
		!to_wdt |-> wdt_timeout == wdt_tick) // RULE2
		else $error("watchdog divided while timer owns prescaler");
	chk_ps_clear_swap: assert property (@(posedge clk) disable iff (!rstn)
		ps_clear |=> !ps_out) // RULE2
		else $error("prescaler fired across owner change");
	chk_stat_wdt_set: assert property (@(posedge clk) disable iff (!rstn)
		to_wdt && wdt_timeout |=> s_q.stat[STAT_WDT_BIT]) // RULE2
		else $error("watchdog tick not recorded");

	// Timer source and edge choice
	chk_src_ext: assert property (@(posedge clk) disable iff (!rstn)
		!to_wdt && s_q.opt[OPT_SRC_BIT] |-> ps_in == src_edge) // RULE7
		else $error("external source not used");
	chk_src_edge_fall: assert property (@(posedge clk) disable iff (!rstn)
		!to_wdt && s_q.opt[OPT_SRC_BIT] && s_q.opt[OPT_SRC_EDGE_BIT] && ps_in
		|-> !s_q.clk_sync[1] && s_q.clk_prev) // RULE7
		else $error("source edge not falling");
	chk_ext_edge_rise: assert property (@(posedge clk) disable iff (!rstn)
		ext_edge && s_q.opt[OPT_EDGE_BIT] |-> s_q.int_sync[1] && !s_q.int_prev) // RULE6
		else $error("pin edge not rising");

	// Pull-ups and register port
	chk_pullup_follow: assert property (@(posedge clk) disable iff (!rstn)
		!s_q.opt[OPT_PULLUP_BIT] |-> pullup_en == port_b_latch) // RULE5
		else $error("pull-ups do not follow latch");
	chk_ctl_reset: assert property (@(posedge clk) $rose(rstn) |-> s_q.ctl == 8'h00) // RULE9
		else $error("control register not clear after reset");
	chk_ctl_write: assert property (@(posedge clk) disable iff (!rstn)
		bus_req.wr && bus_req.addr == IRQCTL_ADDR && !timer_overflow && !ext_edge && !pb_change
		|=> s_q.ctl == $past(bus_req.wdata)) // RULE9
		else $error("control write lost");
	chk_ctl_read_back: assert property (@(posedge clk) disable iff (!rstn)
		bus_req.rd && bus_req.addr == IRQCTL_ADDR |=> rdata == $past(s_q.ctl)) // RULE9
		else $error("control read wrong");
	chk_idle_rdata: assert property (@(posedge clk) disable iff (!rstn)
		!bus_req.rd |=> rdata == 8'h00)
		else $error("read data outside read cycle");
	chk_mask_store: assert property (@(posedge clk) disable iff (!rstn)
		bus_req.wr && bus_req.addr == IRQ_MASK_ADDR |=> s_q.mask == $past(bus_req.wdata[1:0]))
		else $error("mask write lost");

	// Flags and interrupt levels
	chk_port_flag: assert property (@(posedge clk) disable iff (!rstn)
		pb_change |=> s_q.ctl[IRQ_PORT_FLAG_BIT]) // RULE10
		else $error("port change did not set flag");
	chk_ext_no_enable: assert property (@(posedge clk) disable iff (!rstn)
		ext_edge && !s_q.ctl[IRQ_EXT_EN_BIT] |=> s_q.ctl[IRQ_EXT_FLAG_BIT]) // RULE10
		else $error("pin flag not set while disabled");
	chk_irq_gated: assert property (@(posedge clk) disable iff (!rstn)
		!s_q.ctl[IRQ_GIE_BIT] |-> !cpu_irq) // RULE11
		else $error("interrupt without global enable");
	chk_stat_clear: assert property (@(posedge clk) disable iff (!rstn)
		bus_req.wr && bus_req.addr == IRQ_STAT_ADDR && bus_req.wdata[STAT_TICK_BIT]
		&& !(ps_out && !to_wdt) |=> !s_q.stat[STAT_TICK_BIT])
		else $error("status bit not cleared");

	cov_wdt_assign: cover property (@(posedge clk) disable iff (!rstn) to_wdt && ps_out);
	cov_wdt_bypass: cover property (@(posedge clk) disable iff (!rstn) wdt_bypass && wdt_tick);
	cov_ext_flag: cover property (@(posedge clk) disable iff (!rstn) ext_edge);
	cov_timer_tick: cover property (@(posedge clk) disable iff (!rstn) !to_wdt && timer_tick);
	cov_cpu_irq: cover property (@(posedge clk) disable iff (!rstn) cpu_irq);
endmodule : tpo_option_ctrl

// [verilog/tpo_prescaler.sv]
// Shared 8-bit prescaler: divides a tick stream by a power of two.
// Assumes tick_in is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module tpo_prescaler
	import tpo_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [2:0] shift,
	output logic tick_out
);
	typedef struct packed
	{
		logic [WIDTH-1:0] cnt;
		logic out;
	} tpo_ps_state_t;
	tpo_ps_state_t s_q, s_d;
	logic [WIDTH-1:0] mask;

	always_comb
	begin
		// Widen the shift before adding one; a 3-bit sum would wrap code 7 to 1:1
		mask = WIDTH'((1 << (int'(shift) + 1)) - 1);
		s_d = s_q;
		s_d.out = 1'b0;
		if (clear)
		begin
			s_d.cnt = '0;
		end
		else if (tick_in)
		begin
			s_d.cnt = s_q.cnt + WIDTH'(1);
			if ((s_d.cnt & mask) == '0)
			begin
				s_d.out = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign tick_out = s_q.out;
endmodule : tpo_prescaler
